// *** include/nsx_pkg.sv ***
// package: opcodes, operand ranges, result routing and carrier types for the exec block
`default_nettype none
package nsx_pkg;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned NIB_W         = 4;
  localparam logic [6:0]  DIR_SEL_A     = 7'h05;
  localparam logic [6:0]  DIR_SEL_B     = 7'h06;
  localparam logic [6:0]  DIR_SEL_C     = 7'h07;
  localparam logic        DEST_W        = 1'h0;
  localparam logic        DEST_F        = 1'h1;
  localparam logic [7:0]  RESET_W       = 8'h00;
  localparam logic [7:0]  RESET_DIR     = 8'hff;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  typedef enum logic [3:0] {
    NSX_OP_SWAP_NIBBLES   = 4'h1,
    NSX_OP_LOAD_DIRECTION = 4'h2,
    NSX_OP_XOR_LITERAL    = 4'h4,
    NSX_OP_XOR_FILE       = 4'h8
  } nsx_op_t;

  // one decoded instruction as handed over by the core
  typedef struct packed {
    logic       valid;
    nsx_op_t    op;
    logic       dest;
    logic [6:0] faddr;
    logic [7:0] literal;
    logic [7:0] fdata;
  } nsx_instr_t;

  // write-back toward the file register array
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } nsx_fwr_t;
endpackage : nsx_pkg
`default_nettype wire

// *** core/nsx_alu.sv ***
// combinational result and zero-flag logic for the four instructions
`default_nettype none
module nsx_alu
  import nsx_pkg::*;
(
  // operands
  input  wire nsx_op_t    op,
  input  wire logic [7:0] w_val,
  input  wire logic [7:0] f_val,
  input  wire logic [7:0] k_val,
  // result
  output logic [7:0]      result,
  output logic            is_zero
);
  function automatic logic [7:0] nsx_swap(input logic [7:0] v);
    return {v[NIB_W-1:0], v[DATA_W-1:NIB_W]};
  endfunction : nsx_swap

  always_comb begin
    case (op)
      NSX_OP_SWAP_NIBBLES:   result = nsx_swap(f_val);
      NSX_OP_XOR_LITERAL:    result = w_val ^ k_val;
      NSX_OP_XOR_FILE:       result = w_val ^ f_val;
      NSX_OP_LOAD_DIRECTION: result = w_val;
      default:               result = w_val;
    endcase
    is_zero = (result == ZERO_BYTE);
  end
endmodule : nsx_alu
`default_nettype wire

// *** core/nsx_exec.sv ***
// execution stage for nibble swap, direction load and the two xor instructions
// Behaviour
// - swap_nibbles result: low nibble of f goes high, high nibble goes low.
// - swap_nibbles writes W when dest is 0, f when 1; flags untouched.
// - load_direction copies W into a direction register; operand 5..7; flags untouched.
// - operand 5 selects port A, 6 port B, 7 port C direction.
// - xor_literal: W becomes W xor 8-bit literal; only zero flag changes.
// - xor_file: W xor f to W (dest 0) or f (dest 1); zero only.
`default_nettype none
module nsx_exec
  import nsx_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // decoded instruction, one per instruction cycle
  input  wire nsx_instr_t instr,
  // working register and status
  output logic [7:0]      w_reg,
  output logic            zero_reg,
  // file write-back
  output nsx_fwr_t        fwr_reg,
  // port direction registers and out-of-range direction flag
  output logic [7:0]      port_a_direction,
  output logic [7:0]      port_b_direction,
  output logic [7:0]      port_c_direction,
  output logic            dir_bad_reg
);
  logic [7:0] result;
  logic       is_zero;
  logic       ex_swap;
  logic       ex_dir;
  logic       ex_xorl;
  logic       ex_xorf;
  logic       dir_ok;

  // one result path and zero test shared by all four instructions
  nsx_alu u_alu (
    .op      (instr.op),
    .w_val   (w_reg),
    .f_val   (instr.fdata),
    .k_val   (instr.literal),
    .result  (result),
    .is_zero (is_zero)
  );

  // one-hot opcode decode; valid gates every side effect
  assign ex_swap = instr.valid && (instr.op == NSX_OP_SWAP_NIBBLES);
  assign ex_dir  = instr.valid && (instr.op == NSX_OP_LOAD_DIRECTION);
  assign ex_xorl = instr.valid && (instr.op == NSX_OP_XOR_LITERAL);
  assign ex_xorf = instr.valid && (instr.op == NSX_OP_XOR_FILE);
  // operands outside 5..7 load nothing; flagged for the core
  assign dir_ok  = (instr.faddr >= DIR_SEL_A) && (instr.faddr <= DIR_SEL_C);

  // working register; xor_literal has no destination bit and
  // always lands here
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_reg <= RESET_W;
    end else if (ex_xorl) begin
      w_reg <= result;
    end else if ((ex_swap || ex_xorf) && instr.dest == DEST_W) begin
      w_reg <= result;
    end
  end

  // zero flag; swap and direction load leave it alone
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_reg <= 1'b0;
    end else if (ex_xorl || ex_xorf) begin
      zero_reg <= is_zero;
    end
  end

  // file write-back, one-cycle strobe
  // addr and data follow every cycle and only wr qualifies them,
  // which keeps extra muxing off the write-back path
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fwr_reg <= '0;
    end else begin
      fwr_reg.wr   <= (ex_swap || ex_xorf) && instr.dest == DEST_F;
      fwr_reg.addr <= instr.faddr;
      fwr_reg.data <= result;
    end
  end

  // direction registers reset to all inputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_direction <= RESET_DIR;
      port_b_direction <= RESET_DIR;
      port_c_direction <= RESET_DIR;
    end else if (ex_dir) begin
      case (instr.faddr)
        DIR_SEL_A: port_a_direction <= w_reg;
        DIR_SEL_B: port_b_direction <= w_reg;
        DIR_SEL_C: port_c_direction <= w_reg;
        // unselected operands fall through and load nothing
        default: begin
        end
      endcase
    end
  end

  // out-of-range pulse for the core; one cycle wide, and no
  // direction register moves with it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_bad_reg <= 1'b0;
    end else begin
      dir_bad_reg <= ex_dir && !dir_ok;
    end
  end

  // reference values built from the operands alone, so the checks below
  // do not lean on the alu they are meant to watch
  logic [7:0] swap_expect;
  logic [7:0] xorl_expect;
  logic [7:0] xorf_expect;
  logic       any_exec;

  assign swap_expect = {instr.fdata[NIB_W-1:0], instr.fdata[DATA_W-1:NIB_W]};
  assign xorl_expect = w_reg ^ instr.literal;
  assign xorf_expect = w_reg ^ instr.fdata;
  assign any_exec    = ex_swap || ex_dir || ex_xorl || ex_xorf;

  // swap_nibbles: result routing, flags untouched
  swap_result_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_swap && instr.dest == DEST_W |=> w_reg == $past(swap_expect) && !fwr_reg.wr)
    else $error("swap result wrong");

  swap_file_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_swap && instr.dest == DEST_F |=> fwr_reg.data == $past(swap_expect)
      && fwr_reg.addr == $past(instr.faddr))
    else $error("swap file data wrong");

  swap_flags_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_swap |=> $stable(zero_reg))
    else $error("swap changed zero flag");

  swap_dest_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_swap && instr.dest == DEST_F |=> fwr_reg.wr && $stable(w_reg))
    else $error("swap destination wrong");

  fwr_pulse_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    !((ex_swap || ex_xorf) && instr.dest == DEST_F) |=> !fwr_reg.wr)
    else $error("spurious file write");

  // load_direction: only the selected direction register moves
  dir_flags_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_dir |=> $stable(zero_reg) && $stable(w_reg) && !fwr_reg.wr)
    else $error("direction load side effect");

  dir_range_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_dir && !dir_ok |=> dir_bad_reg && $stable(port_a_direction)
      && $stable(port_b_direction) && $stable(port_c_direction))
    else $error("out of range direction load");

  dir_pulse_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(ex_dir && !dir_ok) |=> !dir_bad_reg)
    else $error("spurious direction flag");

  dir_port_a_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_dir && instr.faddr == DIR_SEL_A |=> port_a_direction == $past(w_reg)
      && $stable(port_b_direction) && $stable(port_c_direction))
    else $error("port a direction wrong");

  dir_select_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_dir && instr.faddr == DIR_SEL_B |=> port_b_direction == $past(w_reg)
      && $stable(port_a_direction) && $stable(port_c_direction))
    else $error("direction select wrong");

  dir_port_c_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_dir && instr.faddr == DIR_SEL_C |=> port_c_direction == $past(w_reg)
      && $stable(port_a_direction) && $stable(port_b_direction))
    else $error("port c direction wrong");

  // xor_literal and xor_file
  // xor_literal ignores the destination bit entirely
  xorl_value_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_xorl |=> w_reg == $past(xorl_expect) && !fwr_reg.wr)
    else $error("xor literal wrong");

  xorf_wreg_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_xorf && instr.dest == DEST_W |=> w_reg == $past(xorf_expect) && !fwr_reg.wr)
    else $error("xor file to w wrong");

  xorf_file_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_xorf && instr.dest == DEST_F |=> fwr_reg.wr && $stable(w_reg)
      && fwr_reg.data == $past(xorf_expect) && fwr_reg.addr == $past(instr.faddr))
    else $error("xor file write wrong");

  w_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(ex_xorl || ((ex_swap || ex_xorf) && instr.dest == DEST_W)) |=> $stable(w_reg))
    else $error("w changed without a w destination");

  // zero flag follows only the two xor instructions;
  // swap and direction load must leave it alone
  zero_flag_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_xorl |=> zero_reg == ($past(xorl_expect) == ZERO_BYTE))
    else $error("zero flag wrong");

  zero_file_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    ex_xorf |=> zero_reg == ($past(xorf_expect) == ZERO_BYTE))
    else $error("zero flag after xor file wrong");

  zero_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(ex_xorl || ex_xorf) |=> $stable(zero_reg))
    else $error("zero flag moved without xor");

  // nothing but write-back addr and data moves for an idle cycle or an unknown opcode;
  // an unknown opcode must behave exactly like valid low
  idle_hold_a : assert property (@(posedge sys_clk) disable iff (!reset_n)
    !any_exec |=> $stable(w_reg) && !fwr_reg.wr && !dir_bad_reg
      && $stable(port_a_direction) && $stable(port_b_direction)
      && $stable(port_c_direction))
    else $error("idle cycle changed state");
endmodule : nsx_exec
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the nsx exec stage
`default_nettype none
module tb_top
  import nsx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  w;
    logic        z;
    nsx_fwr_t    f;
    logic [23:0] d;
    logic        bad;
  } nsx_note_t;
  logic        sys_clk;
  logic        reset_n;
  nsx_instr_t  instr;
  logic [7:0]  w_reg;
  logic        zero_reg;
  nsx_fwr_t    fwr_reg;
  logic [7:0]  dir_a;
  logic [7:0]  dir_b;
  logic [7:0]  dir_c;
  logic        dir_bad_reg;
  logic [7:0]  w_m = RESET_W;
  logic        z_m = 1'b0;
  logic [23:0] dir_m = {3{RESET_DIR}};
  logic [31:0] seed = 32'h9f947dc5;
  int          n_fail = 0;
  int          n_tests = 0;
  nsx_note_t   q[$];
  nsx_op_t     opc[5] = '{NSX_OP_SWAP_NIBBLES, NSX_OP_LOAD_DIRECTION, NSX_OP_XOR_LITERAL,
                          NSX_OP_XOR_FILE, nsx_op_t'(4'h3)};

  nsx_exec dut (.sys_clk(sys_clk), .reset_n(reset_n), .instr(instr), .w_reg(w_reg),
    .zero_reg(zero_reg), .fwr_reg(fwr_reg), .port_a_direction(dir_a),
    .port_b_direction(dir_b), .port_c_direction(dir_c), .dir_bad_reg(dir_bad_reg));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // present one instruction, note its expected effect, wait for its edge
  task automatic issue(input nsx_op_t op, input logic d, input logic [6:0] a,
                       input logic [7:0] k, input logic [7:0] f, input logic v);
    nsx_note_t n;
    logic [7:0] r;
    // write-back addr and data follow every instruction; wr alone qualifies them
    r = (op == NSX_OP_SWAP_NIBBLES) ? {f[3:0], f[7:4]} :
        (op == NSX_OP_XOR_FILE) ? (w_m ^ f) :
        (op == NSX_OP_XOR_LITERAL) ? (w_m ^ k) : w_m;
    n = '{w: w_m, z: z_m, f: '{wr: 1'b0, addr: a, data: r}, d: dir_m, bad: 1'b0};
    if (v && op inside {NSX_OP_XOR_LITERAL, NSX_OP_XOR_FILE}) n.z = (r == ZERO_BYTE);
    if (v && op inside {NSX_OP_SWAP_NIBBLES, NSX_OP_XOR_FILE}) begin
      if (d == DEST_F) n.f.wr = 1'b1;
      else n.w = r;
    end
    if (v && op == NSX_OP_XOR_LITERAL) n.w = r;
    if (v && op == NSX_OP_LOAD_DIRECTION) begin
      if (a inside {[DIR_SEL_A:DIR_SEL_C]}) n.d[(7 - a) * 8 +: 8] = w_m;
      else n.bad = 1'b1;
    end
    w_m = n.w;
    z_m = n.z;
    dir_m = n.d;
    q.push_back(n);
    instr = '{valid: v, op: op, dest: d, faddr: a, literal: k, fdata: f};
    @(posedge sys_clk);
    #1;
  endtask : issue

  always @(posedge sys_clk) begin
    if (q.size() > 0) begin
      nsx_note_t n;
      #2;
      n = q.pop_front();
      chk("w", w_reg, n.w);
      chk("zero", zero_reg, n.z);
      chk("fwr", fwr_reg, n.f);
      chk("dirs", {dir_a, dir_b, dir_c}, n.d);
      chk("bad", dir_bad_reg, n.bad);
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #50us;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [2:0] s;
    reset_n = 1'b0;
    instr = '0;
    repeat (16) @(posedge sys_clk);
    #1;
    chk("rst", {zero_reg, fwr_reg}, '0);
    chk("rstw", w_reg, RESET_W);
    chk("rstdir", {dir_a, dir_b, dir_c}, dir_m);
    reset_n = 1'b1;
    issue(NSX_OP_XOR_LITERAL, 1'b0, 7'h00, 8'h0f, 8'h00, 1'b1);
    issue(NSX_OP_XOR_LITERAL, 1'b0, 7'h00, 8'h0f, 8'h00, 1'b1);
    issue(NSX_OP_SWAP_NIBBLES, 1'b1, 7'h21, 8'h00, 8'ha5, 1'b1);
    // boundary operands around the legal direction range back to back
    for (int i = 4; i < 9; i++) issue(NSX_OP_LOAD_DIRECTION, 1'b0, 7'(i), 8'h00, 8'h00, 1'b1);
    repeat (400) begin
      s = 3'(rnd() % 5);
      issue(opc[s], rnd() & 1, (s == 1) ? 7'(4 + rnd() % 5) : rnd(), rnd(), rnd(), rnd() % 8 != 0);
    end
    // asynchronous reset in mid-run, checked while still held
    instr = '0;
    @(posedge sys_clk);
    #1;
    reset_n = 1'b0;
    #1;
    chk("rst2", {zero_reg, fwr_reg}, '0);
    chk("rst2w", w_reg, RESET_W);
    chk("rst2dir", {dir_a, dir_b, dir_c}, {3{RESET_DIR}});
    w_m = RESET_W;
    z_m = 1'b0;
    dir_m = {3{RESET_DIR}};
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    issue(NSX_OP_XOR_LITERAL, 1'b0, 7'h00, 8'h3c, 8'h00, 1'b1);
    issue(NSX_OP_LOAD_DIRECTION, 1'b0, DIR_SEL_A, 8'h00, 8'h00, 1'b1);
    issue(NSX_OP_XOR_FILE, 1'b0, 7'h10, 8'h00, 8'h3c, 1'b1);
    issue(NSX_OP_SWAP_NIBBLES, 1'b0, 7'h10, 8'h00, 8'h5a, 1'b1);
    instr = '0;
    repeat (3) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
